/* common/fasm_map.svh */
// Register offsets, field positions, reset values and counts for the alarm block
`ifndef FASM_MAP_SVH
`define FASM_MAP_SVH

`define FASM_ADDR_SUPPRESS     8'h06
`define FASM_ADDR_STATUS       8'h07

`define FASM_SUPPRESS_RESET    8'h00
`define FASM_STATUS_RESET      8'h00
`define FASM_SUPPRESS_FIELD    8'h7f
`define FASM_STATUS_VALID      8'h6b

`define FASM_BIT_ZERO_PTR      6
`define FASM_BIT_COLLISION     5
`define FASM_BIT_PATTERN       3
`define FASM_BIT_NEAR_TWO      1
`define FASM_BIT_NEAR_ONE      0

`define FASM_AUTO_CLEAR_COUNT  7'h40
`define FASM_WPTR_RESET        8'h01

`endif

/* common/fasm_pkg.sv */
// Types shared by the alarm status and mask block
package fasm_pkg;
  typedef logic [7:0] fasm_byte_t;
  typedef enum logic {
    FASM_AC_IDLE,
    FASM_AC_WATCH
  } fasm_ac_state_t;
endpackage

/* src/fasm_wr_ptr.sv */
// FIFO write pointer kept as a rotating one-hot shift register
`timescale 1ns/1ps
`default_nettype none
`include "fasm_map.svh"
module fasm_wr_ptr
  import fasm_pkg::*;
#(
  parameter int PTR_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             fifo_sync,
  input  wire logic             wr_advance,
  input  wire logic             wr_fault,
  output logic [PTR_W-1:0]      wr_ptr,
  output logic                  ptr_zero
);
  logic [PTR_W-1:0] next_wr_ptr;

  // An all-zero ring rotates into itself, so it stays stuck until sync
  always_comb begin
    next_wr_ptr = wr_ptr;
    if (fifo_sync) begin
      next_wr_ptr = PTR_W'(`FASM_WPTR_RESET);
    end else if (wr_fault) begin
      next_wr_ptr = '0;
    end else if (wr_advance) begin
      next_wr_ptr = {wr_ptr[PTR_W-2:0], wr_ptr[PTR_W-1]};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= PTR_W'(`FASM_WPTR_RESET);
    end else begin
      wr_ptr <= next_wr_ptr;
    end
  end

  assign ptr_zero = (wr_ptr == '0);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_stuck_zero;
    ptr_zero && !fifo_sync |=> ptr_zero;
  endproperty
  a_stuck_zero: assert property (p_stuck_zero) else $error("Zero write pointer left without sync");

  property p_sync_recovers;
    fifo_sync |=> (wr_ptr == PTR_W'(`FASM_WPTR_RESET)) && !ptr_zero;
  endproperty
  a_sync_recovers: assert property (p_sync_recovers) else $error("Sync did not restore write pointer");
endmodule // fasm_wr_ptr
`default_nettype wire

/* src/fasm_ptr_gap.sv */
// Compares one-hot read and write pointers for collision and nearness
`timescale 1ns/1ps
`default_nettype none
module fasm_ptr_gap
  import fasm_pkg::*;
#(
  parameter int PTR_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic [PTR_W-1:0] wr_ptr,
  input  wire logic [PTR_W-1:0] rd_ptr,
  output logic                  collision,
  output logic                  near_one,
  output logic                  near_two
);
  logic next_collision;
  logic next_near_one;
  logic next_near_two;

  function automatic logic [PTR_W-1:0] rotl(input logic [PTR_W-1:0] p, input int n);
    logic [2*PTR_W-1:0] d;
    d = {p, p} << n;
    return d[2*PTR_W-1:PTR_W];
  endfunction

  function automatic logic gap_is(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b, input int n);
    return (rotl(a, n) == b) || (rotl(b, n) == a);
  endfunction

  // A zero pointer is not an address, so it never counts as near
  always_comb begin
    next_collision = (wr_ptr == rd_ptr) && (wr_ptr != '0);
    next_near_one  = (wr_ptr != '0) && gap_is(wr_ptr, rd_ptr, 1);
    next_near_two  = (wr_ptr != '0) && (gap_is(wr_ptr, rd_ptr, 1) || gap_is(wr_ptr, rd_ptr, 2));
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      collision <= 1'b0;
      near_one  <= 1'b0;
      near_two  <= 1'b0;
    end else begin
      collision <= next_collision;
      near_one  <= next_near_one;
      near_two  <= next_near_two;
    end
  end
endmodule // fasm_ptr_gap
`default_nettype wire

/* src/fasm_alarm.sv */
// Alarm status flags, pin suppress mask and auto clear for the input FIFO
//
// Contract
// - Suppress bit set keeps alarm off pin.
// - Suppressed alarms still set status flags.
// - All-zero write pointer sets status bit 6.
// - Zero write pointer stays stuck until sync.
// - Pointer overrun or underrun sets bit 5.
// - Pattern mismatch sets status bit 3.
// - Pointers within two addresses set bit 1.
// - Pointers within one address set bit 0.
// - Status resets zero, sticky until host clears or auto clear fires.
// - Suppress bit 7 reserved, no alarm function.
// - Near alarms reported only when enabled.
// - Auto clear after 64 consecutive good samples.
`timescale 1ns/1ps
`default_nettype none
`include "fasm_map.svh"
module fasm_alarm
  import fasm_pkg::*;
#(
  parameter int PTR_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic [7:0]            reg_rdata,
  input  wire logic             near_two_alarm_enable,
  input  wire logic             near_one_alarm_enable,
  input  wire logic             auto_clear_enable,
  input  wire logic             fifo_sync,
  input  wire logic             wr_advance,
  input  wire logic             wr_fault,
  input  wire logic [PTR_W-1:0] rd_ptr,
  input  wire logic             sample_valid,
  input  wire logic [7:0]       sample_word,
  input  wire logic [7:0]       expected_word,
  output logic [PTR_W-1:0]      wr_ptr,
  output logic                  alarm_out_pin
);
  fasm_byte_t     alarm_status_flags;
  fasm_byte_t     alarm_pin_suppress;
  fasm_byte_t     next_status;
  fasm_byte_t     next_suppress;
  fasm_byte_t     next_rdata;
  fasm_byte_t     events;
  fasm_byte_t     host_clear;
  fasm_byte_t     pin_sources;
  logic           next_pin;
  logic           ptr_zero;
  logic           collision;
  logic           near_one;
  logic           near_two;
  logic           pattern_miss;
  logic           good_sample;
  logic           auto_clear;
  logic [6:0]     good_count;
  logic [6:0]     next_good_count;
  fasm_ac_state_t ac_state;
  fasm_ac_state_t next_ac_state;

  fasm_wr_ptr #(
    .PTR_W      (PTR_W)
  ) u_wr_ptr (
    .mclk       (mclk),
    .rstn       (rstn),
    .fifo_sync  (fifo_sync),
    .wr_advance (wr_advance),
    .wr_fault   (wr_fault),
    .wr_ptr     (wr_ptr),
    .ptr_zero   (ptr_zero)
  );

  fasm_ptr_gap #(
    .PTR_W     (PTR_W)
  ) u_ptr_gap (
    .mclk      (mclk),
    .rstn      (rstn),
    .wr_ptr    (wr_ptr),
    .rd_ptr    (rd_ptr),
    .collision (collision),
    .near_one  (near_one),
    .near_two  (near_two)
  );

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  // Alarm events gathered into their status bit positions
  always_comb begin
    pattern_miss = sample_valid && (sample_word != expected_word);
    events = '0;
    events[`FASM_BIT_ZERO_PTR]  = ptr_zero;
    events[`FASM_BIT_COLLISION] = collision;
    events[`FASM_BIT_PATTERN]   = pattern_miss;
    events[`FASM_BIT_NEAR_TWO]  = near_two && near_two_alarm_enable;
    events[`FASM_BIT_NEAR_ONE]  = near_one && near_one_alarm_enable;
    good_sample = sample_valid && (events == '0);
  end

  // Auto clear starts watching once a flag is up and counts good samples until it fires
  always_comb begin
    next_ac_state   = ac_state;
    next_good_count = good_count;
    auto_clear      = 1'b0;
    if (!auto_clear_enable) begin
      next_ac_state   = FASM_AC_IDLE;
      next_good_count = '0;
    end else begin
      unique case (ac_state)
        FASM_AC_IDLE: begin
          next_good_count = '0;
          if (alarm_status_flags != '0) begin
            next_ac_state = FASM_AC_WATCH;
          end
        end
        FASM_AC_WATCH: begin
          if (events != '0) begin
            next_good_count = '0;
          end else if (good_sample) begin
            if (good_count == `FASM_AUTO_CLEAR_COUNT - 7'h01) begin
              auto_clear      = 1'b1;
              next_good_count = '0;
              next_ac_state   = FASM_AC_IDLE;
            end else begin
              next_good_count = good_count + 7'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ac_state   <= FASM_AC_IDLE;
      good_count <= '0;
    end else begin
      ac_state   <= next_ac_state;
      good_count <= next_good_count;
    end
  end

  // Write one to clear; a new event in the same cycle wins over the clear
  always_comb begin
    host_clear = '0;
    if (reg_wr && addr_hit(reg_addr, `FASM_ADDR_STATUS)) begin
      host_clear = reg_wdata;
    end
    if (auto_clear) begin
      host_clear = 8'hff;
    end
    next_status = ((alarm_status_flags & ~host_clear) | events) & `FASM_STATUS_VALID;
    next_suppress = alarm_pin_suppress;
    if (reg_wr && addr_hit(reg_addr, `FASM_ADDR_SUPPRESS)) begin
      next_suppress = reg_wdata;
    end
  end

  // Bit 7 of suppress is stored but never reaches the pin gating
  always_comb begin
    pin_sources = alarm_status_flags & ~(alarm_pin_suppress & `FASM_SUPPRESS_FIELD);
    next_pin    = |pin_sources;
    unique case (1'b1)
      addr_hit(reg_addr, `FASM_ADDR_STATUS):   next_rdata = alarm_status_flags;
      addr_hit(reg_addr, `FASM_ADDR_SUPPRESS): next_rdata = alarm_pin_suppress;
      default:                                 next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      alarm_status_flags <= `FASM_STATUS_RESET;
      alarm_pin_suppress <= `FASM_SUPPRESS_RESET;
      alarm_out_pin      <= 1'b0;
      reg_rdata          <= '0;
    end else begin
      alarm_status_flags <= next_status;
      alarm_pin_suppress <= next_suppress;
      alarm_out_pin      <= next_pin;
      reg_rdata          <= next_rdata;
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_status_write(int b);
    reg_wr && addr_hit(reg_addr, `FASM_ADDR_STATUS) && reg_wdata[b];
  endsequence

  sequence s_flag_set(int b);
    ##1 alarm_status_flags[b];
  endsequence

  property p_pin_gating;
    ##1 alarm_out_pin == |$past(alarm_status_flags & ~alarm_pin_suppress & `FASM_SUPPRESS_FIELD);
  endproperty
  a_pin_gating: assert property (p_pin_gating) else $error("Alarm pin disagrees with unsuppressed flags");

  sequence s_pin_up;
    ##1 alarm_out_pin;
  endsequence

  property p_pin_follows;
    alarm_status_flags[`FASM_BIT_PATTERN] && !alarm_pin_suppress[`FASM_BIT_PATTERN] |-> s_pin_up;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("Unsuppressed flag did not raise the pin");

  property p_suppressed_captured;
    collision && alarm_pin_suppress[`FASM_BIT_COLLISION] |-> s_flag_set(`FASM_BIT_COLLISION);
  endproperty
  a_suppressed_captured: assert property (p_suppressed_captured) else $error("Suppressed alarm not captured");

  property p_zero_ptr_flag;
    ptr_zero |-> s_flag_set(`FASM_BIT_ZERO_PTR);
  endproperty
  a_zero_ptr_flag: assert property (p_zero_ptr_flag) else $error("Zero pointer alarm missing");

  property p_collision_flag;
    collision |-> s_flag_set(`FASM_BIT_COLLISION);
  endproperty
  a_collision_flag: assert property (p_collision_flag) else $error("Collision alarm missing");

  property p_pattern_flag;
    sample_valid && (sample_word != expected_word) |-> s_flag_set(`FASM_BIT_PATTERN);
  endproperty
  a_pattern_flag: assert property (p_pattern_flag) else $error("Pattern mismatch alarm missing");

  property p_near_two_flag;
    near_two && near_two_alarm_enable |-> s_flag_set(`FASM_BIT_NEAR_TWO);
  endproperty
  a_near_two_flag: assert property (p_near_two_flag) else $error("Near two alarm missing");

  property p_near_one_flag;
    near_one && near_one_alarm_enable |-> s_flag_set(`FASM_BIT_NEAR_ONE);
  endproperty
  a_near_one_flag: assert property (p_near_one_flag) else $error("Near one alarm missing");

  property p_near_disabled;
    !near_one_alarm_enable && !alarm_status_flags[`FASM_BIT_NEAR_ONE] |=> !alarm_status_flags[`FASM_BIT_NEAR_ONE];
  endproperty
  a_near_disabled: assert property (p_near_disabled) else $error("Disabled near alarm was set");

  property p_near_two_disabled;
    !near_two_alarm_enable && !alarm_status_flags[`FASM_BIT_NEAR_TWO] |=> !alarm_status_flags[`FASM_BIT_NEAR_TWO];
  endproperty
  a_near_two_disabled: assert property (p_near_two_disabled) else $error("Disabled near two alarm was set");

  property p_sticky;
    alarm_status_flags[`FASM_BIT_PATTERN] && !auto_clear
      && !(reg_wr && addr_hit(reg_addr, `FASM_ADDR_STATUS) && reg_wdata[`FASM_BIT_PATTERN])
      |=> alarm_status_flags[`FASM_BIT_PATTERN];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Flag dropped without a clear");

  property p_host_clear;
    s_status_write(`FASM_BIT_COLLISION) ##0 !collision |=> !alarm_status_flags[`FASM_BIT_COLLISION];
  endproperty
  a_host_clear: assert property (p_host_clear) else $error("Write to clear had no effect");

  property p_auto_clear;
    auto_clear && (events == '0) |=> (alarm_status_flags == '0) ##1 (alarm_out_pin == 1'b0);
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("Auto clear left flags set");

  property p_auto_clear_cause;
    auto_clear |-> auto_clear_enable && good_sample && (good_count == `FASM_AUTO_CLEAR_COUNT - 7'h01);
  endproperty
  a_auto_clear_cause: assert property (p_auto_clear_cause) else $error("Auto clear before 64 good samples");

  // Own run of good samples; a clear after fewer than 64 would be early
  logic [6:0] chk_good_run;
  logic [6:0] next_chk_good_run;

  always_comb begin
    next_chk_good_run = chk_good_run;
    if (!auto_clear_enable || (events != '0) || auto_clear) begin
      next_chk_good_run = '0;
    end else if (good_sample && (chk_good_run != 7'h7f)) begin
      next_chk_good_run = chk_good_run + 7'h01;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chk_good_run <= '0;
    end else begin
      chk_good_run <= next_chk_good_run;
    end
  end

  property p_auto_clear_run;
    auto_clear |-> (chk_good_run >= `FASM_AUTO_CLEAR_COUNT - 7'h01);
  endproperty
  a_auto_clear_run: assert property (p_auto_clear_run) else $error("Auto clear after too short a good run");

  property p_reserved_zero;
    (alarm_status_flags & ~`FASM_STATUS_VALID) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved status bit set");
endmodule // fasm_alarm
`default_nettype wire

/* bench/fasm_host_model.sv */
// Host model: register writes, reads and fifo_sync pulse for resync
`timescale 1ns/1ps
`default_nettype none
module fasm_host_model
  import fasm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            fifo_sync
);
  initial begin
    reg_wr    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    fifo_sync = 1'b0;
  end

  // Write-one clears status bits; flags stay set until this write or an auto clear
  task automatic wr_reg(input fasm_byte_t addr, input fasm_byte_t data);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // Idle data bus shows no stale value
    reg_wdata <= ~data;
  endtask

  // Read data is registered, so allow settling edges
  task automatic rd_reg(input fasm_byte_t addr, output fasm_byte_t data);
    @(posedge mclk);
    reg_addr <= addr;
    repeat (3) @(posedge mclk);
    #1;
    data = reg_rdata;
  endtask

  // Sync bit set then returned to 0; needed after zero pointer alarm
  task automatic resync();
    @(posedge mclk);
    fifo_sync <= 1'b1;
    @(posedge mclk);
    fifo_sync <= 1'b0;
  endtask
endmodule // fasm_host_model
`default_nettype wire

/* bench/fasm_alarm_test.sv */
// Self-checking testbench for the alarm status and mask block
`timescale 1ns/1ps
`default_nettype none
module fasm_alarm_test
  import fasm_pkg::*;
;
  logic       mclk;
  logic       rstn;
  logic       reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       near_two_alarm_enable;
  logic       near_one_alarm_enable;
  logic       auto_clear_enable;
  logic       fifo_sync;
  logic       wr_advance;
  logic       wr_fault;
  logic [7:0] rd_ptr;
  logic       sample_valid;
  logic [7:0] sample_word;
  logic [7:0] expected_word;
  logic [7:0] wr_ptr;
  logic       alarm_out_pin;
  int         num_errors;
  int         total_checks;

  fasm_alarm #(.PTR_W(8)) i_dut (
    .mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .near_two_alarm_enable(near_two_alarm_enable),
    .near_one_alarm_enable(near_one_alarm_enable), .auto_clear_enable(auto_clear_enable),
    .fifo_sync(fifo_sync), .wr_advance(wr_advance), .wr_fault(wr_fault), .rd_ptr(rd_ptr),
    .sample_valid(sample_valid), .sample_word(sample_word), .expected_word(expected_word),
    .wr_ptr(wr_ptr), .alarm_out_pin(alarm_out_pin)
  );

  fasm_host_model i_host (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .fifo_sync(fifo_sync)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input fasm_byte_t got, input fasm_byte_t exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input fasm_byte_t addr, input fasm_byte_t exp);
    fasm_byte_t v;
    i_host.rd_reg(addr, v);
    chk(v, exp);
  endtask

  task automatic samples(input int n, input fasm_byte_t w, input fasm_byte_t e);
    repeat (n) begin
      @(posedge mclk);
      sample_valid  <= 1'b1;
      sample_word   <= w;
      expected_word <= e;
    end
    @(posedge mclk);
    sample_valid <= 1'b0;
    sample_word  <= ~w;
  endtask

  task automatic t_reset();
    chk_reg(8'h07, 8'h00);
    chk_reg(8'h06, 8'h00);
    chk_reg(8'h05, 8'h00);
    chk(wr_ptr, 8'h01);
    chk({7'h00, alarm_out_pin}, 8'h00);
    i_host.wr_reg(8'h06, 8'hff);
    chk_reg(8'h06, 8'hff);
    i_host.wr_reg(8'h05, 8'h5a);
    chk_reg(8'h05, 8'h00);
    i_host.wr_reg(8'h06, 8'h00);
  endtask

  task automatic t_pattern();
    samples(1, 8'h3c, 8'h3d);
    chk_reg(8'h07, 8'h08);
    chk({7'h00, alarm_out_pin}, 8'h01);
    i_host.wr_reg(8'h07, 8'h00);
    chk_reg(8'h07, 8'h08);
    i_host.wr_reg(8'h07, 8'h08);
    chk_reg(8'h07, 8'h00);
    chk({7'h00, alarm_out_pin}, 8'h00);
  endtask

  task automatic t_masked();
    i_host.wr_reg(8'h06, 8'h08);
    samples(2, 8'h11, 8'h91);
    chk_reg(8'h07, 8'h08);
    chk({7'h00, alarm_out_pin}, 8'h00);
    // Only the reserved bit set: the alarm reaches the pin again
    i_host.wr_reg(8'h06, 8'h80);
    chk_reg(8'h07, 8'h08);
    chk({7'h00, alarm_out_pin}, 8'h01);
    i_host.wr_reg(8'h06, 8'h00);
    i_host.wr_reg(8'h07, 8'hff);
  endtask

  task automatic near_case(input fasm_byte_t rp, input logic en2, input logic en1, input fasm_byte_t exp);
    @(posedge mclk);
    rd_ptr <= rp;
    near_two_alarm_enable <= en2;
    near_one_alarm_enable <= en1;
    chk_reg(8'h07, exp);
    @(posedge mclk);
    rd_ptr <= 8'h10;
    repeat (3) @(posedge mclk);
    i_host.wr_reg(8'h07, 8'hff);
  endtask

  task automatic t_near();
    near_case(8'h02, 1'b0, 1'b0, 8'h00);
    near_case(8'h02, 1'b1, 1'b1, 8'h03);
    near_case(8'h02, 1'b1, 1'b0, 8'h02);
    near_case(8'h02, 1'b0, 1'b1, 8'h01);
    near_case(8'h04, 1'b1, 1'b1, 8'h02);
    near_case(8'h10, 1'b1, 1'b1, 8'h00);
    near_case(8'h01, 1'b0, 1'b0, 8'h20);
  endtask

  task automatic t_zero();
    @(posedge mclk);
    wr_fault <= 1'b1;
    @(posedge mclk);
    wr_fault   <= 1'b0;
    wr_advance <= 1'b1;
    repeat (3) @(posedge mclk);
    wr_advance <= 1'b0;
    chk_reg(8'h07, 8'h40);
    chk(wr_ptr, 8'h00);
    chk({7'h00, alarm_out_pin}, 8'h01);
    i_host.resync();
    @(posedge mclk);
    #1;
    chk(wr_ptr, 8'h01);
    i_host.wr_reg(8'h07, 8'h40);
    chk_reg(8'h07, 8'h00);
  endtask

  task automatic t_auto();
    @(posedge mclk);
    auto_clear_enable <= 1'b1;
    samples(1, 8'h22, 8'h23);
    // 63 good samples leave the flag, the 64th clears it
    samples(63, 8'h55, 8'h55);
    chk_reg(8'h07, 8'h08);
    samples(1, 8'h66, 8'h66);
    chk_reg(8'h07, 8'h00);
    chk({7'h00, alarm_out_pin}, 8'h00);
  endtask

  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    num_errors            = 0;
    total_checks          = 0;
    rstn                  = 1'b0;
    near_two_alarm_enable = 1'b0;
    near_one_alarm_enable = 1'b0;
    auto_clear_enable     = 1'b0;
    wr_advance            = 1'b0;
    wr_fault              = 1'b0;
    rd_ptr                = 8'h10;
    sample_valid          = 1'b0;
    sample_word           = 8'h00;
    expected_word         = 8'h00;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_pattern();
    t_masked();
    t_near();
    t_zero();
    t_auto();
    results();
  end
endmodule // fasm_alarm_test
`default_nettype wire
